// >>> mig_consts.svh
// Constants for the maskable interrupt gating block
`ifndef MIG_CONSTS_SVH
`define MIG_CONSTS_SVH

// Register byte addresses on the APB
`define MIG_ADDR_PRI_A    16'hff20
`define MIG_ADDR_PRI_B    16'hff21
`define MIG_ADDR_EN_PORT  16'hff23
`define MIG_ADDR_EN_TMR   16'hff24
`define MIG_ADDR_EN_DSP   16'hff25
`define MIG_ADDR_FL_PORT  16'hff27
`define MIG_ADDR_FL_TMR   16'hff28
`define MIG_ADDR_FL_DSP   16'hff29
`define MIG_ADDR_MASK     16'hff2c
`define MIG_ADDR_STATUS   16'hff2d

// Reset values
`define MIG_RST_BYTE      8'h00
`define MIG_RST_MASK      2'h0

// Implemented bits per flag / enable register
`define MIG_IMPL_PORT     8'hf8
`define MIG_IMPL_TMR      8'hff
`define MIG_IMPL_DSP      8'hfc

// Priority field positions (low bit of each two-bit field)
`define MIG_PF_PORT1      6
`define MIG_PF_PORT0      4
`define MIG_PF_TMR1       2
`define MIG_PF_TMR0       0
`define MIG_PF_BYTE_TMR   6
`define MIG_PF_SERIAL     4
`define MIG_PF_CLOCK      2
`define MIG_PF_DISPLAY    0

`define MIG_NUM_FACTORS   19
`define MIG_NO_FACTOR     5'h1f
`define MIG_NMI_LEVEL     3'h4

`endif

// >>> mig_pkg.sv
// Types for the maskable interrupt gating block
package mig_pkg;
   typedef logic [1:0] mig_level_t;
   typedef logic [4:0] mig_factor_t;
   typedef enum logic [2:0] {
      MIG_BUS_IDLE   = 3'b001,
      MIG_BUS_SETUP  = 3'b010,
      MIG_BUS_ACCESS = 3'b100
   } mig_bus_e;
endpackage

// >>> mig_arbiter.sv
// Fixed-order arbiter picking the highest pending level and its factor
`timescale 1ns/1ps
`include "mig_consts.svh"
module mig_arbiter (
   input  wire logic                  i_clk,
   input  wire logic                  i_rst_n,
   input  wire logic [18:0]           i_pending,
   input  wire logic [37:0]           i_levels,
   output logic                       o_valid,
   output mig_pkg::mig_level_t        o_level,
   output mig_pkg::mig_factor_t       o_factor
);
   // Index 0 has highest default order; strict > keeps the earliest on ties
   logic [1:0] best_level;
   logic [4:0] best_factor;
   logic       best_valid;

   always_comb begin
      best_level  = 2'h0;
      best_factor = `MIG_NO_FACTOR;
      best_valid  = 1'b0;
      for (int k = 0; k < `MIG_NUM_FACTORS; k++) begin
         if (i_pending[k] && (!best_valid || i_levels[2*k +: 2] > best_level)) begin
            best_valid  = 1'b1;
            best_level  = i_levels[2*k +: 2];
            best_factor = 5'(k);
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_valid  <= 1'b0;
         o_level  <= 2'h0;
         o_factor <= `MIG_NO_FACTOR;
      end else begin
         o_valid  <= best_valid;
         o_level  <= best_level;
         o_factor <= best_factor;
      end
   end
endmodule

// >>> mig_gate.sv
// Maskable interrupt gating: flags, enables, priorities and CPU request
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "mig_consts.svh"
//
// Contract
// - Nineteen maskable factors in eight systems each own a flag; watchdog has none.
// - A factor event sets its flag to one and holds it.
// - Writing one clears a set flag; writing zero leaves it.
// - Initial reset clears every factor flag.
// - Each flag has an enable; one lets it request, zero blocks.
// - Enable bits read back as last written.
// - Initial reset clears every enable bit.
// - Request only when flag, enable set and level above CPU mask.
// - CPU samples requests at each instruction's first opcode fetch.
// - A flag left set at handler return requests again.
// - Port1 line mismatches: flags bits 4-7, enables 4-7, priority A bits 6-7.
// - Port0 mismatch: flag bit 3, enable bit 3, priority A bits 4-5.
// - Timer0 underflow/compare: bits 3,4; priority A bits 0-1.
// - Timer1 underflow/compare: bits 5,6; priority A bits 2-3.
// - Display transfer done: bit 2; priority B bits 0-1.
// - Clock ticks and minute overflow: bits 3-7; priority B bits 2-3.
// - Priority field encodes levels 0 to 3; zero never interrupts.
// - Equal levels resolve by fixed default order; intra-system order fixed.
// - Initial reset clears every priority field to level zero.
// - Watchdog request acts at level four, regardless of CPU mask.
module mig_gate (
   input  wire logic        i_clk,
   input  wire logic        i_arst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [15:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [3:0]  i_port1_mismatch,
   input  wire logic        i_port0_mismatch,
   input  wire logic        i_timer0_underflow,
   input  wire logic        i_timer0_compare,
   input  wire logic        i_timer1_underflow,
   input  wire logic        i_timer1_compare,
   input  wire logic        i_byte_timer_underflow,
   input  wire logic        i_serial_rx_error,
   input  wire logic        i_serial_rx_done,
   input  wire logic        i_serial_tx_done,
   input  wire logic        i_display_xfer_done,
   input  wire logic [3:0]  i_tick_fall,
   input  wire logic        i_minute_overflow,
   input  wire logic        i_watchdog_nmi,
   input  wire logic [1:0]  i_cpu_mask,
   input  wire logic        i_opcode_fetch,
   output logic             o_irq_req,
   output logic [2:0]       o_irq_level,
   output logic [4:0]       o_irq_factor,
   output logic             o_irq_sample
);
   // ******************************************************************
   // Reset release
   // ******************************************************************
   logic rst_meta;
   logic rst_n;
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ******************************************************************
   // APB decode
   // ******************************************************************
   function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
      hit = (a == r);
   endfunction

   // Write-one-clear with set winning over clear
   function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] set,
                                      input logic [7:0] clr, input logic [7:0] impl);
      w1c = ((cur & ~clr) | set) & impl;
   endfunction

   wire        wr_en     = psel && penable && pwrite;
   wire [7:0]  wbyte     = pwdata[7:0];
   wire        sel_pri_a = hit(paddr, `MIG_ADDR_PRI_A);
   wire        sel_pri_b = hit(paddr, `MIG_ADDR_PRI_B);
   wire        sel_en_p  = hit(paddr, `MIG_ADDR_EN_PORT);
   wire        sel_en_t  = hit(paddr, `MIG_ADDR_EN_TMR);
   wire        sel_en_d  = hit(paddr, `MIG_ADDR_EN_DSP);
   wire        sel_fl_p  = hit(paddr, `MIG_ADDR_FL_PORT);
   wire        sel_fl_t  = hit(paddr, `MIG_ADDR_FL_TMR);
   wire        sel_fl_d  = hit(paddr, `MIG_ADDR_FL_DSP);
   wire        sel_mask  = hit(paddr, `MIG_ADDR_MASK);
   wire        sel_stat  = hit(paddr, `MIG_ADDR_STATUS);
   wire        mapped    = sel_pri_a | sel_pri_b | sel_en_p | sel_en_t | sel_en_d |
                           sel_fl_p | sel_fl_t | sel_fl_d | sel_mask | sel_stat;

   // ******************************************************************
   // Registers
   // ******************************************************************
   logic [7:0] priority_select_a;
   logic [7:0] priority_select_b;
   logic [7:0] input_port_enables;
   logic [7:0] timer_serial_enables;
   logic [7:0] display_clock_enables;
   logic [7:0] input_port_flags;
   logic [7:0] timer_serial_flags;
   logic [7:0] display_clock_flags;

   // Event vectors placed at their flag bit positions
   wire [7:0] set_port = {i_port1_mismatch, i_port0_mismatch, 3'h0};
   wire [7:0] set_tmr  = {i_byte_timer_underflow, i_timer1_compare,
                          i_timer1_underflow, i_timer0_compare,
                          i_timer0_underflow, i_serial_tx_done,
                          i_serial_rx_done, i_serial_rx_error};
   wire [7:0] set_dsp  = {i_minute_overflow, i_tick_fall[0], i_tick_fall[1],
                          i_tick_fall[2], i_tick_fall[3], i_display_xfer_done,
                          2'h0};

   wire [7:0] clr_port = (wr_en && sel_fl_p) ? wbyte : `MIG_RST_BYTE;
   wire [7:0] clr_tmr  = (wr_en && sel_fl_t) ? wbyte : `MIG_RST_BYTE;
   wire [7:0] clr_dsp  = (wr_en && sel_fl_d) ? wbyte : `MIG_RST_BYTE;

   wire [7:0] next_fl_p = w1c(input_port_flags, set_port, clr_port, `MIG_IMPL_PORT);
   wire [7:0] next_fl_t = w1c(timer_serial_flags, set_tmr, clr_tmr, `MIG_IMPL_TMR);
   wire [7:0] next_fl_d = w1c(display_clock_flags, set_dsp, clr_dsp, `MIG_IMPL_DSP);

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         input_port_flags    <= `MIG_RST_BYTE;
         timer_serial_flags  <= `MIG_RST_BYTE;
         display_clock_flags <= `MIG_RST_BYTE;
      end else begin
         input_port_flags    <= next_fl_p;
         timer_serial_flags  <= next_fl_t;
         display_clock_flags <= next_fl_d;
      end
   end

   flag_impl_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      ((input_port_flags & ~`MIG_IMPL_PORT) == `MIG_RST_BYTE
         && (display_clock_flags & ~`MIG_IMPL_DSP) == `MIG_RST_BYTE))
      else $error("unimplemented flag bit set");

   // Set beats a same-cycle clear so no event is lost
   set_wins_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      i_display_xfer_done |=> display_clock_flags[2])
      else $error("display event lost");

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         input_port_enables    <= `MIG_RST_BYTE;
         timer_serial_enables  <= `MIG_RST_BYTE;
         display_clock_enables <= `MIG_RST_BYTE;
         priority_select_a     <= `MIG_RST_BYTE;
         priority_select_b     <= `MIG_RST_BYTE;
      end else if (wr_en) begin
         if (sel_en_p)  input_port_enables    <= wbyte & `MIG_IMPL_PORT;
         if (sel_en_t)  timer_serial_enables  <= wbyte & `MIG_IMPL_TMR;
         if (sel_en_d)  display_clock_enables <= wbyte & `MIG_IMPL_DSP;
         if (sel_pri_a) priority_select_a     <= wbyte;
         if (sel_pri_b) priority_select_b     <= wbyte;
      end
   end

   en_rst_a: assert property (@(posedge i_clk)
      $rose(rst_n) |-> (input_port_enables == `MIG_RST_BYTE
         && timer_serial_enables == `MIG_RST_BYTE && priority_select_b == `MIG_RST_BYTE))
      else $error("enables not cleared by reset");

   // Enables only move on a write to their own address
   en_keep_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      !(wr_en && sel_en_p) |=> $stable(input_port_enables))
      else $error("port enables changed without write");

   // ******************************************************************
   // Per-factor level and pending vectors, default order index 0 first
   // ******************************************************************
   function automatic logic [1:0] fld(input logic [7:0] r, input int pos);
      fld = r[pos +: 2];
   endfunction

   wire [1:0] lv_p1 = fld(priority_select_a, `MIG_PF_PORT1);
   wire [1:0] lv_p0 = fld(priority_select_a, `MIG_PF_PORT0);
   wire [1:0] lv_t0 = fld(priority_select_a, `MIG_PF_TMR0);
   wire [1:0] lv_t1 = fld(priority_select_a, `MIG_PF_TMR1);
   wire [1:0] lv_bt = fld(priority_select_b, `MIG_PF_BYTE_TMR);
   wire [1:0] lv_si = fld(priority_select_b, `MIG_PF_SERIAL);
   wire [1:0] lv_ld = fld(priority_select_b, `MIG_PF_DISPLAY);
   wire [1:0] lv_ct = fld(priority_select_b, `MIG_PF_CLOCK);

   wire [7:0] act_p = input_port_flags & input_port_enables;
   wire [7:0] act_t = timer_serial_flags & timer_serial_enables;
   wire [7:0] act_d = display_clock_flags & display_clock_enables;

   // Order follows the vector table: port1 lines, port0, timers, serial, display, clock
   wire [18:0] factor_on = {act_d[7:2], act_t[2:0], act_t[7:3], act_p[3], act_p[7:4]};
   wire [37:0] factor_lv = {{6{lv_ct}} & {{5{2'h3}}, 2'h0} | {10'h0, lv_ld},
                            {3{lv_si}}, lv_bt, lv_t1, lv_t1, lv_t0, lv_t0,
                            lv_p0, {4{lv_p1}}};
   wire [18:0] factor_ok;
   genvar g;
   generate
      for (g = 0; g < `MIG_NUM_FACTORS; g++) begin : g_ok
         // Level above mask; level 0 never passes since mask is at least 0
         assign factor_ok[g] = factor_on[g] && (factor_lv[2*g +: 2] > i_cpu_mask);
      end
   endgenerate

   logic       arb_valid;
   logic [1:0] arb_level;
   logic [4:0] arb_factor;

   mig_arbiter u_arbiter (
      .i_clk     (i_clk),
      .i_rst_n   (rst_n),
      .i_pending (factor_ok),
      .i_levels  (factor_lv),
      .o_valid   (arb_valid),
      .o_level   (arb_level),
      .o_factor  (arb_factor)
   );

   // ******************************************************************
   // CPU request outputs
   // ******************************************************************
   // Watchdog bypasses the mask entirely
   wire       next_req    = i_watchdog_nmi | arb_valid;
   wire [2:0] next_level  = i_watchdog_nmi ? `MIG_NMI_LEVEL : {1'b0, arb_level};
   wire [4:0] next_factor = i_watchdog_nmi ? `MIG_NO_FACTOR : arb_factor;

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_irq_req    <= 1'b0;
         o_irq_level  <= 3'h0;
         o_irq_factor <= `MIG_NO_FACTOR;
         o_irq_sample <= 1'b0;
      end else begin
         o_irq_req    <= next_req;
         o_irq_level  <= next_level;
         o_irq_factor <= next_factor;
         o_irq_sample <= i_opcode_fetch && next_req;
      end
   end

   // Level zero means off, never a request
   lvl_zero_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      (o_irq_req && !o_irq_level[2]) |-> o_irq_level[1:0] != 2'h0)
      else $error("level zero request");

   sample_req_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      o_irq_sample |-> o_irq_req)
      else $error("sample without request");

   // A maskable winner always names a real factor
   win_known_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      (o_irq_req && !o_irq_level[2]) |-> o_irq_factor < 5'(`MIG_NUM_FACTORS))
      else $error("winner factor out of range");

   // Even the top mask level cannot hold the watchdog off
   nmi_mask_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      (i_watchdog_nmi && i_cpu_mask == 2'h3) |=> o_irq_level == `MIG_NMI_LEVEL)
      else $error("watchdog held off by mask");

   // ******************************************************************
   // APB read and response
   // ******************************************************************
   wire [7:0] status_byte = {o_irq_req, o_irq_level, 4'h0};
   wire [7:0] rd_byte =
      sel_pri_a ? priority_select_a :
      sel_pri_b ? priority_select_b :
      sel_en_p  ? input_port_enables :
      sel_en_t  ? timer_serial_enables :
      sel_en_d  ? display_clock_enables :
      sel_fl_p  ? input_port_flags :
      sel_fl_t  ? timer_serial_flags :
      sel_fl_d  ? display_clock_flags :
      sel_mask  ? {6'h0, i_cpu_mask} :
      sel_stat  ? status_byte : `MIG_RST_BYTE;

   // Zero wait-state: pready rises at the edge that ends the setup cycle and starts the first access cycle
   wire setup_cyc = psel && !penable;
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setup_cyc;
         pslverr <= setup_cyc && !mapped;
         prdata  <= setup_cyc ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   err_rdy_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      pslverr |-> pready) else $error("error without ready");

   // Idle read data is zero so stale bytes never leak
   rdata_idle_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      !pready |-> prdata == 32'h0000_0000) else $error("read data outside answer");

   // ******************************************************************
   // Checks
   // ******************************************************************
   flag_set_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      i_timer0_underflow |=> timer_serial_flags[3])
      else $error("timer0 underflow did not set flag");

   flag_hold_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      (input_port_flags[3] && !(wr_en && sel_fl_p && wbyte[3])) |=> input_port_flags[3])
      else $error("port0 flag dropped without clear");

   flag_clr_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      (wr_en && sel_fl_d && wbyte[2] && !i_display_xfer_done) |=> !display_clock_flags[2])
      else $error("display flag not cleared by write one");

   en_wr_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      (wr_en && sel_en_t) |=> timer_serial_enables == $past(wbyte))
      else $error("enable write not stored");

   gate_mask_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      (!i_watchdog_nmi && factor_ok == 19'h0) |-> ##2 (!o_irq_req || $past(i_watchdog_nmi)
         || $past(factor_ok, 2) != 19'h0)) else $error("request without cause");

   nmi_level_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      i_watchdog_nmi |=> (o_irq_req && o_irq_level == 3'h4))
      else $error("watchdog not at level four");

   pri_reset_a: assert property (@(posedge i_clk)
      $rose(rst_n) |-> (priority_select_a == 8'h00 && input_port_flags == 8'h00))
      else $error("reset values wrong");

   win_level_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      (factor_ok[0] && !i_watchdog_nmi) ##1 !i_watchdog_nmi |=> (o_irq_req
         && o_irq_level[1:0] >= $past(lv_p1, 2))) else $error("winner level too low");

   apb_rdy_a: assert property (@(posedge i_clk) disable iff (!rst_n)
      (psel && !penable) |=> pready) else $error("apb not answered in one cycle");
endmodule

// >>> mig_cpu_model.sv
// Behavioural CPU core that fetches opcodes and takes interrupts
`timescale 1ns/1ps
// ****************************************
// CPU side of the request interface
// ****************************************
module mig_cpu_model #(
   parameter int HANDLER_CYCLES = 12
) (
   input  wire logic       i_clk,
   input  wire logic       i_arst_n,
   input  wire logic       i_take,
   input  wire logic [1:0] i_base_mask,
   input  wire logic [3:0] i_fetch_gap,
   input  wire logic       i_irq_sample,
   input  wire logic [2:0] i_irq_level,
   output logic      [1:0] o_cpu_mask,
   output logic            o_opcode_fetch,
   output logic      [7:0] o_accepts
);
   logic [3:0] gap_cnt;
   logic [4:0] busy;
   logic [1:0] held_mask;

   // Handler never clears the flag itself, so a left flag re-enters
   assign o_cpu_mask = (busy != 5'h00) ? held_mask : i_base_mask;

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         gap_cnt        <= 4'h0;
         busy           <= 5'h00;
         held_mask      <= 2'h0;
         o_opcode_fetch <= 1'b0;
         o_accepts      <= 8'h00;
      end else begin
         gap_cnt        <= (gap_cnt == 4'h0) ? i_fetch_gap : gap_cnt - 4'h1;
         o_opcode_fetch <= (gap_cnt == 4'h0);
         if (i_irq_sample && i_take && busy == 5'h00) begin
            busy      <= 5'(HANDLER_CYCLES);
            held_mask <= (i_irq_level == 3'h4) ? 2'h3 : i_irq_level[1:0];
            o_accepts <= o_accepts + 8'h01;
         end else if (busy != 5'h00) begin
            busy <= busy - 5'h01;
         end
      end
   end
endmodule

// >>> mig_gate_test.sv
// Self-checking testbench for the maskable interrupt gating block
`timescale 1ns/1ps
`include "mig_consts.svh"
module mig_gate_test;
   logic        i_clk = 1'b0;
   logic        i_arst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready, pslverr, o_irq_req, o_irq_sample, i_opcode_fetch;
   logic        nmi = 1'b0;
   logic        take = 1'b0;
   logic [18:0] ev = 19'h0_0000;
   logic [1:0]  base_mask = 2'h0;
   logic [1:0]  i_cpu_mask;
   logic [2:0]  o_irq_level;
   logic [4:0]  o_irq_factor;
   logic [7:0]  accepts, a0;
   logic [32:0] r;
   int          num_errors = 0;
   int          n_checks = 0;
   int          cycles = 0;
   localparam int BITP [19] = '{4, 5, 6, 7, 3, 3, 4, 5, 6, 7, 0, 1, 2, 2, 3, 4, 5, 6, 7};
   localparam int PSH [19] = '{6, 6, 6, 6, 4, 0, 0, 2, 2, 6, 4, 4, 4, 0, 2, 2, 2, 2, 2};
   localparam logic [15:0] ADDRS [8] = '{`MIG_ADDR_PRI_A, `MIG_ADDR_PRI_B, `MIG_ADDR_EN_PORT,
      `MIG_ADDR_EN_TMR, `MIG_ADDR_EN_DSP, `MIG_ADDR_FL_PORT, `MIG_ADDR_FL_TMR, `MIG_ADDR_FL_DSP};

   always #5 i_clk = ~i_clk;

   mig_gate mig_gate_i (.i_clk(i_clk), .i_arst_n(i_arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .i_port1_mismatch(ev[3:0]), .i_port0_mismatch(ev[4]),
      .i_timer0_underflow(ev[5]), .i_timer0_compare(ev[6]), .i_timer1_underflow(ev[7]),
      .i_timer1_compare(ev[8]), .i_byte_timer_underflow(ev[9]), .i_serial_rx_error(ev[10]),
      .i_serial_rx_done(ev[11]), .i_serial_tx_done(ev[12]), .i_display_xfer_done(ev[13]),
      .i_tick_fall({ev[14], ev[15], ev[16], ev[17]}), .i_minute_overflow(ev[18]),
      .i_watchdog_nmi(nmi), .i_cpu_mask(i_cpu_mask), .i_opcode_fetch(i_opcode_fetch),
      .o_irq_req(o_irq_req), .o_irq_level(o_irq_level), .o_irq_factor(o_irq_factor),
      .o_irq_sample(o_irq_sample));

   mig_cpu_model mig_cpu_model_i (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_take(take),
      .i_base_mask(base_mask), .i_fetch_gap(4'h3), .i_irq_sample(o_irq_sample),
      .i_irq_level(o_irq_level), .o_cpu_mask(i_cpu_mask), .o_opcode_fetch(i_opcode_fetch),
      .o_accepts(accepts));

   // ****************************************
   // Checking and bus tasks
   // ****************************************
   task automatic finish_test;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk_reg(input logic [32:0] got, input logic [32:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t reg got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_irq(input logic [8:0] got, input logic [8:0] exp, input logic [8:0] care);
      n_checks++;
      if ((got & care) !== (exp & care)) begin
         num_errors++;
         $display("BAD %0t irq got %h exp %h", $time, got, exp);
      end
   endtask

   // Holds the request until pready is sampled high at a rising edge
   task automatic apb(input logic wr, input logic [15:0] a, input logic [7:0] d,
                      output logic [32:0] res);
      @(posedge i_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= {24'h00_0000, d};
      @(posedge i_clk);
      penable <= 1'b1;
      do begin
         @(posedge i_clk);
      end while (pready !== 1'b1);
      res = {pslverr, prdata};
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      logic [32:0] q;
      apb(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      logic [32:0] q;
      apb(1'b0, a, 8'h00, q);
      chk_reg(q, {9'h000, 16'h0000, e});
   endtask

   // Request path takes two to three edges, then poll a few more
   task automatic wait_irq(input logic [8:0] exp, input logic [8:0] care);
      int n;
      n = 0;
      repeat (3) @(negedge i_clk);
      while ((({o_irq_req, o_irq_level, o_irq_factor} & care) !== (exp & care)) && n < 6) begin
         @(negedge i_clk);
         n++;
      end
      chk_irq({o_irq_req, o_irq_level, o_irq_factor}, exp, care);
   endtask

   task automatic pulse(input int i);
      @(posedge i_clk);
      ev <= 19'h0_0001 << i;
      @(posedge i_clk);
      ev <= 19'h0_0000;
   endtask

   function automatic logic [15:0] fl(input int i);
      return (i < 5) ? `MIG_ADDR_FL_PORT : (i < 13) ? `MIG_ADDR_FL_TMR : `MIG_ADDR_FL_DSP;
   endfunction

   function automatic logic [15:0] pa(input int i);
      return (i < 9) ? `MIG_ADDR_PRI_A : `MIG_ADDR_PRI_B;
   endfunction

   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 40000) begin
         num_errors++;
         finish_test();
      end
   end

   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      repeat (20) @(posedge i_clk);
      i_arst_n <= 1'b1;
      repeat (3) @(posedge i_clk);
      foreach (ADDRS[k]) rd(ADDRS[k], 8'h00);
      wait_irq(9'h000, 9'h100);
      apb(1'b0, 16'hff22, 8'h00, r);
      chk_reg(r, {1'b1, 32'h0000_0000});
      for (int i = 0; i < 19; i++) begin
         pulse(i);
         rd(fl(i), 8'h01 << BITP[i]);
         wait_irq(9'h000, 9'h100);
         wr(fl(i) - 16'h0004, 8'h01 << BITP[i]);
         rd(fl(i) - 16'h0004, 8'h01 << BITP[i]);
         wr(pa(i), 8'h03 << PSH[i]);
         wait_irq({1'b1, 3'h3, 5'(i)}, 9'h1ff);
         wr(fl(i), 8'h00);
         rd(fl(i), 8'h01 << BITP[i]);
         wr(fl(i), 8'h01 << BITP[i]);
         rd(fl(i), 8'h00);
         wait_irq(9'h000, 9'h100);
         wr(fl(i) - 16'h0004, 8'h00);
         wr(pa(i), 8'h00);
      end
      // Every level against every mask on timer 1 underflow
      pulse(7);
      wr(`MIG_ADDR_EN_TMR, 8'h20);
      for (int l = 0; l < 4; l++) begin
         for (int m = 0; m < 4; m++) begin
            wr(`MIG_ADDR_PRI_A, 8'(l << 2));
            base_mask <= 2'(m);
            wait_irq({l > m, 3'(l), 5'd7}, (l > m) ? 9'h1ff : 9'h100);
         end
      end
      // Equal levels, then a raised level, then order inside one system
      @(posedge i_clk);
      base_mask <= 2'h0;
      pulse(0);
      pulse(8);
      wr(`MIG_ADDR_EN_PORT, 8'h10);
      wr(`MIG_ADDR_EN_TMR, 8'h60);
      wr(`MIG_ADDR_PRI_A, 8'h88);
      wait_irq({1'b1, 3'h2, 5'd0}, 9'h1ff);
      wr(`MIG_ADDR_PRI_A, 8'h8c);
      wait_irq({1'b1, 3'h3, 5'd7}, 9'h1ff);
      wr(`MIG_ADDR_FL_TMR, 8'h20);
      wait_irq({1'b1, 3'h3, 5'd8}, 9'h1ff);
      @(posedge i_clk);
      base_mask <= 2'h3;
      wait_irq(9'h000, 9'h100);
      @(posedge i_clk);
      nmi <= 1'b1;
      wait_irq({1'b1, 3'h4, 5'h1f}, 9'h1ff);
      @(posedge i_clk);
      nmi <= 1'b0;
      base_mask <= 2'h0;
      // Handler returns without clearing: the same request comes back
      take <= 1'b1;
      a0 = accepts;
      repeat (80) @(posedge i_clk);
      chk_reg({32'h0000_0000, accepts > a0 + 8'h01}, 33'h0_0000_0001);
      wr(`MIG_ADDR_FL_PORT, 8'hf8);
      wr(`MIG_ADDR_FL_TMR, 8'hff);
      repeat (20) @(posedge i_clk);
      a0 = accepts;
      repeat (60) @(posedge i_clk);
      chk_reg({25'h000_0000, accepts}, {25'h000_0000, a0});
      finish_test();
   end
endmodule
